/* File: inc/serial_eeprom_bus_slave_write_map.vh */
`ifndef SERIAL_EEPROM_BUS_SLAVE_WRITE_MAP_VH
`define SERIAL_EEPROM_BUS_SLAVE_WRITE_MAP_VH
// Operation
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Sample data on rising clock edge
// - Receiver pulls data low in ninth pulse
// - Respond only when strap bits match
// - Direction bit one reads, zero writes
// - Match acks, mismatch returns to standby
// - Two address bytes, high first, acked
// - Program only on stop after data ack
// - Counter points past last written byte
// - Busy programming: no ack, polling allowed
// - Write protect high refuses data bytes
// - Write protect still acks select, address
// - Byte write acked only when unprotected
// - Page write buffers up to 32 bytes
// - In-page address wraps at page end
// - ID page write uses low five bits
// - Locked ID page refuses all data bytes
// - Lock command sets page read-only forever; code clears the lock on reset_n
// - Four-byte aligned groups protected together
// - Byte write reprograms its whole group

`define ST_IDLE 3'h0
`define ST_DEVSEL 3'h1
`define ST_ADDRH 3'h2
`define ST_ADDRL 3'h3
`define ST_DATA 3'h4
`define ST_IGNORE 3'h5
`define ST_PROG 3'h6

`define PAGE_BYTES 32
`define GROUP_BYTES 4
`define BYTE_BITS 4'h8
`define SEL_RW_BIT 0
`define LOCK_SEL_BIT 10
`define LOCK_DATA_BIT 1
// Type identifiers are arbitrary values
`define MEM_TYPE_ID 4'h5
`define ID_TYPE_ID 4'h6
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 10000
`define PROG_CYCLES 20'h003e8
`endif

/* File: src/serial_eeprom_bus_slave_write.v */
`timescale 1ns/1ps
`include "serial_eeprom_bus_slave_write_map.vh"
module serial_eeprom_bus_slave_write #(
	parameter ECC_FITTED = 1,
	parameter [3:0] MEM_TYPE_ID = `MEM_TYPE_ID,
	parameter [3:0] ID_TYPE_ID = `ID_TYPE_ID,
	parameter [19:0] PROG_CYCLES = `PROG_CYCLES
)(
	input wire core_clk,
	input wire reset_n,
	input wire clkEn,
	input wire sclIn,
	input wire sdaIn,
	output wire sdaOut,
	output wire sdaOe,
	input wire [2:0] chipSelectStraps,
	input wire writeProtectInput,
	output wire busy,
	output wire idPageLocked,
	output wire [15:0] addrCounter,
	output reg memWrEn,
	output reg [15:0] memWrAddr,
	output reg [7:0] memWrData,
	output reg memWrKeep,
	output reg memWrIdPage
);

// Pin sampling
reg [2:0] sclSync_ff;
reg [2:0] sdaSync_ff;
reg [2:0] strapMeta_ff;
reg [2:0] strap_ff;
reg wpMeta_ff;
reg wp_ff;

// Protocol state
reg [2:0] state_ff;
reg [3:0] bitCnt_ff;
reg [7:0] shift_ff;
reg ackPhase_ff;
reg sdaOe_ff;
reg idMode_ff;
reg lockMode_ff;
reg lockPending_ff;
reg haveData_ff;
reg idLocked_ff;

// Address, pointers and programming
reg [15:0] addr_ff;
reg [4:0] ptr_ff;
reg [4:0] lastPtr_ff;
reg [31:0] mask_ff;
reg [19:0] progCnt_ff;

// Decode
wire [31:0] groupHit;
wire sclHigh;
wire startDet;
wire stopDet;
wire sclRise;
wire sclFall;
wire active;
wire byteEnd;
wire [3:0] selType;
wire selMatch;
wire dataOk;
wire lockOk;
wire [4:0] slot;
wire [19:0] progLast;

// Select fields and engine helpers
wire selIsMem;
wire selIsId;
wire strapsMatch;
wire selRead;
wire [255:0] pageFlat;
wire bufLoad;
wire bitTake;
wire stopTrig;
wire progDone;
wire progSlotOn;

// Pin synchronisers, stage 2 onward feeds logic
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		sclSync_ff <= 3'h7;
		sdaSync_ff <= 3'h7;
		strapMeta_ff <= 3'h0;
		strap_ff <= 3'h0;
		wpMeta_ff <= 1'b0;
		wp_ff <= 1'b0;
	end else if (clkEn) begin
		sclSync_ff <= {sclSync_ff[1:0], sclIn};
		sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
		strapMeta_ff <= chipSelectStraps;
		strap_ff <= strapMeta_ff;
		wpMeta_ff <= writeProtectInput;
		wp_ff <= wpMeta_ff;
	end
end

assign sclHigh = sclSync_ff[1] & sclSync_ff[2];
assign startDet = sclHigh & sdaSync_ff[2] & ~sdaSync_ff[1];
assign stopDet = sclHigh & ~sdaSync_ff[2] & sdaSync_ff[1];
assign sclRise = sclSync_ff[1] & ~sclSync_ff[2];
assign sclFall = ~sclSync_ff[1] & sclSync_ff[2];
assign active = (state_ff >= `ST_DEVSEL) && (state_ff <= `ST_DATA);
assign byteEnd = active && (bitCnt_ff == `BYTE_BITS) && sclFall &&
	!ackPhase_ff;

assign selType = shift_ff[7:4];
// Select byte fields
assign selIsMem = (selType == MEM_TYPE_ID);
assign selIsId = (selType == ID_TYPE_ID);
assign strapsMatch = (shift_ff[3:1] == strap_ff);
assign selRead = shift_ff[`SEL_RW_BIT];
assign selMatch = (selIsMem || selIsId) && strapsMatch;

// Data bytes refused under protect or locked ID page
assign dataOk = !wp_ff && !(idMode_ff && idLocked_ff);
assign lockOk = dataOk && !lockPending_ff &&
	shift_ff[`LOCK_DATA_BIT];

// Group coverage for rewrite of whole aligned groups
genvar g;
generate
	for (g = 0; g < `PAGE_BYTES; g = g + 1) begin : grp
		if (ECC_FITTED != 0) begin : ecc
			assign groupHit[g] =
				|mask_ff[(g / `GROUP_BYTES) * `GROUP_BYTES +: `GROUP_BYTES];
		end else begin : raw
			assign groupHit[g] = mask_ff[g];
		end
	end
endgenerate

assign slot = progCnt_ff[4:0];
assign progLast = PROG_CYCLES - 20'h1;
// Programming cycle end
assign progDone = (progCnt_ff >= progLast);
// Stop in the slot right after a data ack
assign stopTrig = (state_ff == `ST_DATA) && (bitCnt_ff == 4'h1) &&
	!ackPhase_ff && (haveData_ff || lockPending_ff);
// One bit per rising clock edge
assign bitTake = active && sclRise && !ackPhase_ff &&
	(bitCnt_ff < `BYTE_BITS);
assign progSlotOn = (state_ff == `ST_PROG) &&
	(progCnt_ff < `PAGE_BYTES) && groupHit[slot];
assign bufLoad = byteEnd && (state_ff == `ST_DATA) && !lockMode_ff &&
	dataOk;

// Protocol engine
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		state_ff <= `ST_IDLE;
		bitCnt_ff <= 4'h0;
		shift_ff <= 8'h00;
		ackPhase_ff <= 1'b0;
		sdaOe_ff <= 1'b0;
		idMode_ff <= 1'b0;
		lockMode_ff <= 1'b0;
		lockPending_ff <= 1'b0;
		haveData_ff <= 1'b0;
		idLocked_ff <= 1'b0;
		addr_ff <= 16'h0000;
		ptr_ff <= 5'h00;
		lastPtr_ff <= 5'h00;
		mask_ff <= 32'h00000000;
		progCnt_ff <= 20'h00000;
	end else if (clkEn) begin
		if (state_ff == `ST_PROG) begin
			// Bus ignored until the cycle ends
			sdaOe_ff <= 1'b0;
			progCnt_ff <= progCnt_ff + 20'h1;
			if (progDone) begin
				state_ff <= `ST_IDLE;
				progCnt_ff <= 20'h00000;
				if (haveData_ff)
					addr_ff[4:0] <= lastPtr_ff + 5'h01;
				if (lockPending_ff)
					idLocked_ff <= 1'b1;
				mask_ff <= 32'h00000000;
				haveData_ff <= 1'b0;
				lockPending_ff <= 1'b0;
			end
		end else if (startDet) begin
			// Start restarts decoding
			state_ff <= `ST_DEVSEL;
			bitCnt_ff <= 4'h0;
			ackPhase_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			mask_ff <= 32'h00000000;
			haveData_ff <= 1'b0;
			lockPending_ff <= 1'b0;
		end else if (stopDet) begin
			sdaOe_ff <= 1'b0;
			ackPhase_ff <= 1'b0;
			bitCnt_ff <= 4'h0;
			// Stop ends the exchange
			if (stopTrig) begin
				state_ff <= `ST_PROG;
				progCnt_ff <= 20'h00000;
			end else begin
				state_ff <= `ST_IDLE;
				mask_ff <= 32'h00000000;
				haveData_ff <= 1'b0;
				lockPending_ff <= 1'b0;
			end
		end else if (bitTake) begin
			shift_ff <= {shift_ff[6:0], sdaSync_ff[1]};
			bitCnt_ff <= bitCnt_ff + 4'h1;
		end else if (byteEnd) begin
			// Byte complete: decide the ninth slot
			bitCnt_ff <= 4'h0;
			ackPhase_ff <= 1'b1;
			case (state_ff)
				`ST_DEVSEL: begin
					sdaOe_ff <= selMatch;
					idMode_ff <= selIsId;
					if (!selMatch)
						state_ff <= `ST_IGNORE;
					else if (selRead)
						state_ff <= `ST_IGNORE;
					else
						state_ff <= `ST_ADDRH;
				end
				`ST_ADDRH: begin
					sdaOe_ff <= 1'b1;
					addr_ff[15:8] <= shift_ff;
					state_ff <= `ST_ADDRL;
				end
				`ST_ADDRL: begin
					sdaOe_ff <= 1'b1;
					addr_ff[7:0] <= shift_ff;
					ptr_ff <= shift_ff[4:0];
					lockMode_ff <= idMode_ff && addr_ff[`LOCK_SEL_BIT];
					state_ff <= `ST_DATA;
				end
				`ST_DATA: begin
					if (lockMode_ff) begin
						sdaOe_ff <= lockOk;
						lockPending_ff <= lockOk;
					end else if (dataOk) begin
						sdaOe_ff <= 1'b1;
						mask_ff[ptr_ff] <= 1'b1;
						lastPtr_ff <= ptr_ff;
						ptr_ff <= ptr_ff + 5'h01;
						haveData_ff <= 1'b1;
					end else begin
						sdaOe_ff <= 1'b0;
					end
				end
				default: begin
					sdaOe_ff <= 1'b0;
					state_ff <= `ST_IGNORE;
				end
			endcase
		end else if (ackPhase_ff && sclFall) begin
			// Release after the ninth clock pulse
			ackPhase_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
		end
	end
end

// Page buffer, one register per entry
genvar e;
generate
	for (e = 0; e < `PAGE_BYTES; e = e + 1) begin : entry
		localparam [4:0] IDX = e;
		reg [7:0] entryByte_ff;
		always @(posedge core_clk) begin
			if (clkEn && bufLoad && (ptr_ff == IDX)) begin
				entryByte_ff <= shift_ff;
			end
		end
		assign pageFlat[e * 8 +: 8] = entryByte_ff;
	end
endgenerate

// Array write strobes during the programming cycle
always @(posedge core_clk or negedge reset_n) begin
	if (!reset_n) begin
		memWrEn <= 1'b0;
		memWrAddr <= 16'h0000;
		memWrData <= 8'h00;
		memWrKeep <= 1'b0;
		memWrIdPage <= 1'b0;
	end else if (clkEn) begin
		memWrEn <= progSlotOn;
		memWrAddr <= idMode_ff ? {11'h000, slot} :
			{addr_ff[15:5], slot};
		memWrData <= pageFlat[slot * 8 +: 8];
		memWrKeep <= !mask_ff[slot];
		memWrIdPage <= idMode_ff;
	end
end

// Open drain: only ever pulls low
assign sdaOut = 1'b0;
assign sdaOe = sdaOe_ff;
assign busy = (state_ff == `ST_PROG);
assign idPageLocked = idLocked_ff;
assign addrCounter = addr_ff;

endmodule

/* File: testbench/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model(
	input wire core_clk,
	input wire sdaLine,
	output reg sclPin,
	output reg sdaDrive
);
	initial begin
		sclPin = 1'b1;
		sdaDrive = 1'b1;
	end
	task tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Data changes only in clock low
	task bitx(input logic b, output logic s);
		tick(4);
		sdaDrive = b;
		tick(4);
		sclPin = 1'b1;
		tick(4);
		s = sdaLine;
		tick(4);
		sclPin = 1'b0;
	endtask
	// Start is 1 then 0, stop is 0 then 1
	task cond(input logic a, input logic b);
		tick(4);
		sdaDrive = a;
		tick(4);
		sclPin = 1'b1;
		tick(8);
		sdaDrive = b;
		tick(8);
		sclPin = ~a;
	endtask
	// MSB first, then released for ack
	task sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], s);
		end
		bitx(1'b1, s);
		ack = ~s;
	endtask
endmodule

/* File: testbench/serial_eeprom_bus_slave_write_asserts.sv */
`timescale 1ns/1ps
module serial_eeprom_bus_slave_write_asserts #(
	parameter [19:0] PROG_CYCLES = 20'h003e8
)(
	input wire core_clk,
	input wire reset_n,
	input wire sclIn,
	input wire sdaIn,
	input wire sdaOut,
	input wire sdaOe,
	input wire busy,
	input wire idPageLocked,
	input wire memWrEn
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	logic [19:0] busyCnt_ff;
	logic [19:0] nxt_busyCnt;
	assign nxt_busyCnt = busy ? busyCnt_ff + 20'h00001 : 20'h00000;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			busyCnt_ff <= 20'h00000;
		else
			busyCnt_ff <= nxt_busyCnt;
	end
	open_drain_a: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	busy_quiet_a: assert property (busy |-> !sdaOe)
		else $error("ack while programming");
	ack_timing_a: assert property ($rose(sdaOe) |->
		!$past(sclIn, 2) && $past(sclIn, 5))
		else $error("ack not after clock fall");
	ack_hold_a: assert property (sdaOe && $rose(sclIn) |-> sdaOe[*7])
		else $error("ack dropped in clock high");
	prog_trigger_a: assert property ($rose(busy) |->
		sclIn && sdaIn && $past(sclIn, 8))
		else $error("programming without stop");
	busy_length_a: assert property ($fell(busy) |->
		busyCnt_ff == PROG_CYCLES)
		else $error("wrong programming length");
	write_window_a: assert property (memWrEn |-> busy || $past(busy))
		else $error("array write outside busy");
	lock_sticky_a: assert property ($past(idPageLocked) |-> idPageLocked)
		else $error("lock cleared");
endmodule
bind serial_eeprom_bus_slave_write serial_eeprom_bus_slave_write_asserts #(
	.PROG_CYCLES(PROG_CYCLES)
) chkInst (
	.core_clk,
	.reset_n,
	.sclIn,
	.sdaIn,
	.sdaOut,
	.sdaOe,
	.busy,
	.idPageLocked,
	.memWrEn
);

/* File: testbench/serial_eeprom_bus_slave_write_bench.sv */
`timescale 1ns/1ps
module serial_eeprom_bus_slave_write_bench;
	localparam int PROG = 300;
	localparam logic [7:0] SEL = 8'h5a;
	localparam logic [7:0] IDS = 8'h6a;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic [2:0] chipSelectStraps = 3'h5;
	logic writeProtectInput = 1'b0;
	wire sclIn, sdaDrive, sdaOut, sdaOe, busy, idPageLocked;
	wire memWrEn, memWrKeep, memWrIdPage;
	wire [15:0] addrCounter, memWrAddr;
	wire [7:0] memWrData;
	// Pull-up on the data wire
	wire sdaIn = sdaDrive & ~sdaOe;
	int err_count = 0;
	int num_checks = 0;
	int newWr = 0;
	int keepWr = 0;
	logic [15:0] lastAddr = 16'h0000;
	logic [7:0] lastData = 8'h00;
	logic lastId = 1'b0;
	always #5 core_clk = ~core_clk;
	serial_eeprom_bus_slave_write #(.PROG_CYCLES(20'(PROG)))
		serial_eeprom_bus_slave_write_inst (.*);
	bus_master_model bus_master_model_inst (.core_clk, .sdaLine(sdaIn),
		.sclPin(sclIn), .sdaDrive);
	always @(posedge core_clk) begin
		keepWr += memWrEn & memWrKeep;
		newWr += memWrEn & ~memWrKeep;
		if (memWrEn && !memWrKeep) begin
			lastAddr <= memWrAddr;
			lastData <= memWrData;
			lastId <= memWrIdPage;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task settle();
		repeat (PROG) @(negedge core_clk);
		chk(busy, 1'b0);
	endtask
	// Acks expected: select, address, data; then busy after stop
	task wr(input logic [7:0] sel, input logic [15:0] a, input int n,
		input logic [7:0] d, input logic [3:0] ex);
		logic k;
		bus_master_model_inst.cond(1'b1, 1'b0);
		bus_master_model_inst.sendByte(sel, k);
		chk(k, ex[3]);
		for (int i = -2; i < n; i++) begin
			bus_master_model_inst.sendByte(i < 0 ? a[-8 * i - 1 -: 8] :
				d + 8'(i), k);
			chk(k, i < 0 ? ex[2] : ex[1]);
		end
		bus_master_model_inst.cond(1'b0, 1'b1);
		chk(busy, ex[0]);
		$display("transfer done t=%0t", $time);
	endtask
	initial begin
		repeat (20) @(negedge core_clk);
		reset_n = 1'b1;
		bus_master_model_inst.tick(4);
		wr(SEL, 16'h0123, 1, 8'ha5, 4'hf);
		wr(SEL, 16'h0000, -2, 8'h00, 4'h1);
		settle();
		chk(newWr, 16'h0001);
		chk(keepWr, 16'h0003);
		chk(addrCounter, 16'h0124);
		chk(lastAddr, 16'h0123);
		chk(lastData, 8'ha5);
		wr(SEL, 16'h003e, 3, 8'h10, 4'hf);
		settle();
		chk(newWr, 16'h0004);
		chk(keepWr, 16'h0008);
		chk(addrCounter, 16'h0021);
		chk(lastAddr, 16'h003f);
		chk(lastData, 8'h11);
		wr(SEL ^ 8'h02, 16'h0000, -2, 8'h00, 4'h0);
		wr(SEL | 8'h01, 16'h0000, -2, 8'h00, 4'h8);
		writeProtectInput = 1'b1;
		wr(SEL, 16'h0200, 2, 8'h33, 4'hc);
		writeProtectInput = 1'b0;
		wr(SEL, 16'h0200, 0, 8'h00, 4'hc);
		chk(newWr, 16'h0004);
		wr(IDS, 16'hfb05, 1, 8'h77, 4'hf);
		settle();
		chk(addrCounter[4:0], 16'h0006);
		chk(lastAddr, 16'h0005);
		chk(lastData, 8'h77);
		chk(lastId, 1'b1);
		wr(IDS, 16'h0400, 1, 8'h02, 4'hf);
		settle();
		chk(idPageLocked, 1'b1);
		wr(IDS, 16'h0005, 1, 8'h55, 4'hc);
		give_verdict();
	end
	initial begin
		#400us;
		err_count++;
		give_verdict();
	end
endmodule
